// ==== include/pulse_timing_pkg.sv ====
// Purpose: Shared constants and types for the pulse timing and output code block.
// Assumes: 40 MHz reference clock; registers reached through a plain register port.
// Notes: Times are kept in their own units; cycle counts derive from them.
package pulse_timing_pkg;
	localparam int CLK_HZ = 40000000;
	localparam int MS_STEP_US = 1000;
	localparam int HALF_MS_STEP_US = 500;
	// Cycles per timing step; an exact division at 40 MHz.
	localparam int MS_CYCLES = CLK_HZ / 1000000 * MS_STEP_US;
	localparam int HALF_MS_CYCLES = CLK_HZ / 1000000 * HALF_MS_STEP_US;
	localparam logic [7:0] LATENCY_OFFSET = 8'h1d;
	localparam logic [7:0] WINDOW_OFFSET = 8'h1e;
	localparam logic [7:0] DURATION_OFFSET = 8'h1c;
	localparam logic [7:0] TIMING_RESET = 8'h00;
	localparam logic [1:0] ASSIGN_DOUBLE = 2'h2;
	// Output codes for the 8-bit acceleration word.
	localparam logic [7:0] CODE_NEG_FULL = 8'h80;
	localparam logic [7:0] CODE_POS_FULL = 8'h7f;
	localparam logic [7:0] CODE_ZERO = 8'h00;
	localparam logic [7:0] CODE_P1G_2G = 8'h3f;
	localparam logic [7:0] CODE_N1G_2G = 8'hc1;
	localparam logic [7:0] CODE_P1G_4G = 8'h1f;
	localparam logic [7:0] CODE_N1G_4G = 8'he1;
	localparam logic [7:0] CODE_P1G_8G = 8'h0f;
	localparam logic [7:0] CODE_N1G_8G = 8'hf1;
	typedef enum logic [1:0] {
		RANGE_8G = 2'b00,
		RANGE_2G = 2'b01,
		RANGE_4G = 2'b10
	} range_t;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_LATENCY = 2'b01,
		ST_WINDOW = 2'b10
	} pulse_state_t;
	// Register port request.
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_t;
	// Register port answer.
	typedef struct packed {
		logic valid;
		logic [7:0] rdata;
	} reg_rsp_t;
endpackage

// ==== hdl/step_tick.sv ====
// Purpose: Divider giving a one-cycle tick per timing step.
// Assumes: Single clock, asynchronous active-high reset.
// Notes: The count restarts on clear so the first step is whole.
`timescale 1ns/1ps
`default_nettype none
module step_tick #(
	parameter int CYCLES = 40000
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic clear,
	output logic tick
);
	logic [15:0] cnt_r;
	logic [15:0] cnt_nxt;
	logic tick_nxt;

	// Count cycles and pulse when one step has elapsed.
	always_comb begin
		cnt_nxt = cnt_r + 16'h0001;
		tick_nxt = 1'b0;
		if (clear) begin
			cnt_nxt = 16'h0000;
		end else if (cnt_r == 16'(CYCLES - 1)) begin
			cnt_nxt = 16'h0000;
			tick_nxt = 1'b1;
		end
	end

	// Register the divider.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cnt_r <= 16'h0000;
			tick <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			tick <= tick_nxt;
		end
	end
endmodule
`default_nettype wire

// ==== hdl/pulse_timing.sv ====
// Purpose: Double-pulse timing registers and 8-bit acceleration output coding.
// Assumes: Raw pulse events arrive as one-cycle pulses synchronous to ref_clk.
// Notes: Latency and window count 1 ms steps, duration counts 0.5 ms steps.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// R1: Latency register counts 1 ms steps; code 0x01 means 1 ms.
// R2: Latency code 0xFF means 255 ms, linear in the code.
// R3: Window register counts 1 ms steps; 0x01 is 1 ms, 0x00 gives single pulse detection.
// R4: Window code 0xFF means a 255 ms second-pulse window.
// R5: In 2g range codes are 80, C1, 00, 3F, 7F for -2g..+2g.
// R6: 4g gives 80, E1, 1F; 8g gives 80, F1, 0F; full positive 7F.
// R7: Assignment code 10 with latency and window nonzero: second interrupt is double only.
// R8: Duration register counts 0.5 ms steps; code 0x01 is 0.5 ms.
// R9: Timing registers reset to zero and read back the last written value.
module pulse_timing (
	input wire logic ref_clk,
	input wire logic rst,
	input wire pulse_timing_pkg::reg_req_t req,
	output pulse_timing_pkg::reg_rsp_t rsp,
	input wire logic [1:0] interrupt_assign_field,
	input wire logic [1:0] range_select,
	input wire logic [11:0] accel_raw,
	input wire logic pulse_start,
	input wire logic pulse_end,
	output logic pulse_qualified,
	output logic first_interrupt,
	output logic second_interrupt,
	output logic [7:0] accel_code
);
	import pulse_timing_pkg::*;

	logic [7:0] latency_count_r, latency_count_nxt;
	logic [7:0] second_window_count_r, second_window_count_nxt;
	logic [7:0] pulse_duration_count_r, pulse_duration_count_nxt;
	reg_rsp_t rsp_nxt;
	logic ms_tick, half_tick, step_clear;
	pulse_state_t state_r, state_nxt;
	logic [8:0] steps_r, steps_nxt;
	logic [8:0] dur_r, dur_nxt;
	logic in_pulse_r, in_pulse_nxt;
	logic qual_nxt, first_nxt, second_nxt;
	logic [7:0] code_nxt;
	logic [11:0] half_raw;
	logic [11:0] quarter_raw;
	logic double_mode;

	// Register writes and read-back; unmapped reads return zero.
	always_comb begin
		latency_count_nxt = latency_count_r;
		second_window_count_nxt = second_window_count_r;
		pulse_duration_count_nxt = pulse_duration_count_r;
		rsp_nxt.valid = req.rd;
		rsp_nxt.rdata = 8'h00;
		if (req.wr) begin
			case (req.addr)
				LATENCY_OFFSET: latency_count_nxt = req.wdata; // R9
				WINDOW_OFFSET: second_window_count_nxt = req.wdata; // R9
				DURATION_OFFSET: pulse_duration_count_nxt = req.wdata;
				default: ;
			endcase
		end
		if (req.rd) begin
			case (req.addr)
				LATENCY_OFFSET: rsp_nxt.rdata = latency_count_r; // R9
				WINDOW_OFFSET: rsp_nxt.rdata = second_window_count_r; // R9
				DURATION_OFFSET: rsp_nxt.rdata = pulse_duration_count_r;
				default: rsp_nxt.rdata = 8'h00;
			endcase
		end
	end

	// Register file storage, cleared to zero at reset.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			latency_count_r <= TIMING_RESET; // R9
			second_window_count_r <= TIMING_RESET; // R9
			pulse_duration_count_r <= TIMING_RESET;
			rsp <= '0;
		end else begin
			latency_count_r <= latency_count_nxt;
			second_window_count_r <= second_window_count_nxt;
			pulse_duration_count_r <= pulse_duration_count_nxt;
			rsp <= rsp_nxt;
		end
	end

	// Step dividers restart whenever a new interval begins.
	step_tick #(.CYCLES(MS_CYCLES)) u_ms_tick (
		.ref_clk(ref_clk),
		.rst(rst),
		.clear(step_clear),
		.tick(ms_tick)
	);
	step_tick #(.CYCLES(HALF_MS_CYCLES)) u_half_tick (
		.ref_clk(ref_clk),
		.rst(rst),
		.clear(pulse_start),
		.tick(half_tick)
	);

	assign double_mode = (interrupt_assign_field == ASSIGN_DOUBLE)
		&& (latency_count_r != 8'h00)
		&& (second_window_count_r != 8'h00); // R7
	// Any qualified pulse seen in ST_IDLE restarts the step count, in double mode or not.
	assign step_clear = qual_nxt && (state_r == ST_IDLE); // R1

	// Pulse width check, then latency and second-pulse window sequencing.
	always_comb begin
		state_nxt = state_r;
		steps_nxt = steps_r;
		dur_nxt = dur_r;
		in_pulse_nxt = in_pulse_r;
		qual_nxt = 1'b0;
		first_nxt = 1'b0;
		second_nxt = 1'b0;
		if (pulse_start) begin
			in_pulse_nxt = 1'b1;
			dur_nxt = 9'h000;
		end else if (in_pulse_r && half_tick && dur_r != 9'h1ff) begin
			dur_nxt = dur_r + 9'h001; // R8
		end
		// A pulse qualifies if it ends within the programmed duration.
		if (in_pulse_r && pulse_end) begin
			in_pulse_nxt = 1'b0;
			qual_nxt = (dur_r < {1'b0, pulse_duration_count_r}); // R8
		end
		case (state_r)
			ST_IDLE: begin
				if (qual_nxt) begin
					first_nxt = 1'b1;
					second_nxt = !double_mode; // R7
					if (double_mode) begin
						state_nxt = ST_LATENCY;
						steps_nxt = 9'h000;
					end
				end
			end
			ST_LATENCY: begin
				// Pulses during latency are ignored.
				if (ms_tick) begin
					steps_nxt = steps_r + 9'h001; // R1
				end
				if (ms_tick && steps_nxt == {1'b0, latency_count_r}) begin // R2
					state_nxt = ST_WINDOW;
					steps_nxt = 9'h000;
				end
			end
			ST_WINDOW: begin
				if (qual_nxt) begin
					second_nxt = 1'b1; // R7
					state_nxt = ST_IDLE;
				end else if (ms_tick) begin
					steps_nxt = steps_r + 9'h001; // R3
					if (steps_nxt == {1'b0, second_window_count_r}) begin // R4
						state_nxt = ST_IDLE;
					end
				end
			end
			default: state_nxt = ST_IDLE;
		endcase
	end

	// Scale toward zero, so that -1g lands on E1 and F1 rather than below.
	assign half_raw = 12'($signed(accel_raw
		+ {11'h000, accel_raw[11]}) >>> 1); // R6
	assign quarter_raw = 12'($signed(accel_raw
		+ {10'h000, {2{accel_raw[11]}}}) >>> 2); // R6

	// Output coding: signed raw value saturated and scaled per range.
	always_comb begin
		code_nxt = CODE_ZERO;
		case (range_select)
			RANGE_2G: code_nxt = sat8(accel_raw); // R5
			RANGE_4G: code_nxt = sat8(half_raw); // R6
			RANGE_8G: code_nxt = sat8(quarter_raw); // R6
			default: code_nxt = sat8(accel_raw);
		endcase
	end

	// Clamp a 12-bit two's-complement value into 8 bits.
	function automatic logic [7:0] sat8(input logic [11:0] v);
		logic [7:0] r;
		r = v[7:0];
		if (!v[11] && v[10:7] != 4'h0) begin
			r = CODE_POS_FULL;
		end else if (v[11] && v[10:7] != 4'hf) begin
			r = CODE_NEG_FULL;
		end
		return r;
	endfunction

	// Register sequencer state and outputs.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_r <= ST_IDLE;
			steps_r <= 9'h000;
			dur_r <= 9'h000;
			in_pulse_r <= 1'b0;
			pulse_qualified <= 1'b0;
			first_interrupt <= 1'b0;
			second_interrupt <= 1'b0;
			accel_code <= CODE_ZERO;
		end else begin
			state_r <= state_nxt;
			steps_r <= steps_nxt;
			dur_r <= dur_nxt;
			in_pulse_r <= in_pulse_nxt;
			pulse_qualified <= qual_nxt;
			first_interrupt <= first_nxt;
			second_interrupt <= second_nxt;
			accel_code <= code_nxt;
		end
	end
endmodule
`default_nettype wire

// ==== sim/pulse_timing_asserts.sv ====
// Purpose: Port checks for pulse_timing.
// Assumes: One clock, asynchronous active-high reset.
// Notes: Bound to every pulse_timing instance.
`timescale 1ns/1ps
`default_nettype none
module pulse_timing_asserts (
	input wire logic ref_clk,
	input wire logic rst,
	input wire pulse_timing_pkg::reg_req_t req,
	input wire pulse_timing_pkg::reg_rsp_t rsp,
	input wire logic [1:0] interrupt_assign_field,
	input wire logic [1:0] range_select,
	input wire logic [11:0] accel_raw,
	input wire logic pulse_start,
	input wire logic pulse_end,
	input wire logic pulse_qualified,
	input wire logic first_interrupt,
	input wire logic second_interrupt,
	input wire logic [7:0] accel_code
);
	import pulse_timing_pkg::*;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	// A write, then two cycles later a read of the same offset.
	sequence s_wr(a);
		req.wr && req.addr == a;
	endsequence
	sequence s_rd(a);
		req.rd && !req.wr && req.addr == a;
	endsequence
	a_read_answer: assert property (req.rd |=> rsp.valid)
		else $error("read not answered");
	a_answer_cause: assert property (rsp.valid |-> $past(req.rd))
		else $error("answer without read");
	a_unmapped_zero: assert property (req.rd && req.addr > 8'h1e |=>
		rsp.rdata == 8'h00) else $error("unmapped read not zero");
	a_latency_back: assert property (s_wr(8'h1d) ##2 s_rd(8'h1d) |=>
		rsp.rdata == $past(req.wdata, 3)) else $error("latency lost");
	a_window_back: assert property (s_wr(8'h1e) ##2 s_rd(8'h1e) |=>
		rsp.rdata == $past(req.wdata, 3)) else $error("window lost");
	a_code_two: assert property (range_select == 2'h1 &&
		accel_raw == 12'h03f |=> accel_code == 8'h3f) else $error("2g code");
	a_code_four: assert property (range_select == 2'h2 &&
		accel_raw == 12'hfc1 |=> accel_code == 8'he1) else $error("4g code");
	a_code_eight: assert property (range_select == 2'h0 &&
		accel_raw == 12'h03f |=> accel_code == 8'h0f) else $error("8g code");
	a_qual_cause: assert property (pulse_qualified |-> $past(pulse_end))
		else $error("qualified without pulse end");
	a_first_qual: assert property (first_interrupt |-> pulse_qualified)
		else $error("first interrupt without qualified pulse");
endmodule
bind pulse_timing pulse_timing_asserts i_chk (.ref_clk, .rst, .req, .rsp,
	.interrupt_assign_field, .range_select, .accel_raw, .pulse_start,
	.pulse_end, .pulse_qualified, .first_interrupt, .second_interrupt,
	.accel_code);
`default_nettype wire

// ==== sim/host_model.sv ====
// Purpose: Host side of the register port.
// Assumes: Strobes change only just after a rising edge.
// Notes: Released strobes go low; address and data show the inverse of the last value.
`timescale 1ns/1ps
`default_nettype none
module host_model (
	input wire logic ref_clk,
	output var pulse_timing_pkg::reg_req_t req
);
	import pulse_timing_pkg::*;
	initial req = '0;
	// Present one access for a single edge, then release the bus.
	task automatic access(input logic w, input logic [7:0] a,
		input logic [7:0] d);
		@(posedge ref_clk) req <= '{w, !w, a, d};
		@(posedge ref_clk) req <= '{1'b0, 1'b0, ~a, ~d};
	endtask
endmodule
`default_nettype wire

// ==== sim/pulse_timing_tb.sv ====
// Purpose: Self-checking bench for pulse_timing.
// Assumes: 40 MHz clock; host_model drives the register port.
// Notes: Read answers are matched against queued notes.
`timescale 1ns/1ps
`default_nettype none
module pulse_timing_tb;
	import pulse_timing_pkg::*;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic [1:0] mode = 2'h0;
	logic [1:0] rng = 2'h1;
	logic [11:0] raw = 12'h000;
	logic ps = 1'b0;
	logic pe = 1'b0;
	logic pq, fi, si;
	logic [7:0] code, d;
	reg_req_t req;
	reg_rsp_t rsp;
	logic [7:0] exp_q[$];
	logic [1:0] rs[3] = '{2'h1, 2'h2, 2'h0};
	logic [11:0] rw[5] = '{12'h800, 12'hfc1, 12'h000, 12'h03f, 12'h7ff};
	logic [7:0] ct[3][5] = '{'{8'h80, 8'hc1, 8'h00, 8'h3f, 8'h7f},
		'{8'h80, 8'he1, 8'h00, 8'h1f, 8'h7f},
		'{8'h80, 8'hf1, 8'h00, 8'h0f, 8'h7f}};
	int mismatches = 0;
	int n_compared = 0;
	int cyc = 0;
	int n_first = 0;
	int n_second = 0;
	int n_qual = 0;
	pulse_timing i_dut (.ref_clk, .rst, .req, .rsp,
		.interrupt_assign_field(mode), .range_select(rng), .accel_raw(raw),
		.pulse_start(ps), .pulse_end(pe), .pulse_qualified(pq),
		.first_interrupt(fi), .second_interrupt(si), .accel_code(code));
	host_model i_host (.ref_clk, .req);
	initial forever #12.5 ref_clk = ~ref_clk;
	task automatic check8(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic conclude;
		$display("compared %0d mismatched %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// Note the expected byte, then issue the read.
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		i_host.access(1'b0, a, 8'h00);
	endtask
	// A short pulse, well under one duration step.
	task automatic pulse;
		@(posedge ref_clk) ps <= 1'b1;
		@(posedge ref_clk) ps <= 1'b0;
		@(posedge ref_clk) pe <= 1'b1;
		@(posedge ref_clk) pe <= 1'b0;
		repeat (2) @(posedge ref_clk);
	endtask
	// Count interrupts, match read answers, and cut a hang short.
	always @(posedge ref_clk) begin
		cyc++;
		if (fi === 1'b1) n_first++;
		if (si === 1'b1) n_second++;
		if (pq === 1'b1) n_qual++;
		if (rsp.valid === 1'b1) check8(rsp.rdata, exp_q.pop_front());
		if (cyc == 80000) begin
			mismatches++;
			conclude();
		end
	end
	// Main sequence of tests.
	initial begin
		void'($urandom(66));
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		rd(LATENCY_OFFSET, TIMING_RESET);
		rd(WINDOW_OFFSET, TIMING_RESET);
		rd(8'h1f, 8'h00);
		for (int i = 0; i < 3; i++) begin
			d = (i == 0) ? 8'($urandom) : ((i == 1) ? 8'hff : 8'h01);
			i_host.access(1'b1, LATENCY_OFFSET, d);
			rd(LATENCY_OFFSET, d);
			i_host.access(1'b1, WINDOW_OFFSET, d);
			rd(WINDOW_OFFSET, d);
		end
		$display("test registers done");
		for (int r = 0; r < 3; r++) begin
			for (int k = 0; k < 5; k++) begin
				rng <= rs[r];
				raw <= rw[k];
				repeat (2) @(posedge ref_clk);
				check8(code, ct[r][k]);
			end
		end
		$display("test output codes done");
		i_host.access(1'b1, DURATION_OFFSET, 8'h01);
		mode <= ASSIGN_DOUBLE;
		pulse();
		check8(8'(n_first), 8'h01);
		pulse();
		check8(8'(n_second), 8'h00);
		repeat (MS_CYCLES + 2000) @(posedge ref_clk);
		pulse();
		check8(8'(n_second), 8'h01);
		mode <= 2'h0;
		pulse();
		check8(8'(n_second), 8'h02);
		// A pulse longer than one duration step must not qualify.
		@(posedge ref_clk) ps <= 1'b1;
		@(posedge ref_clk) ps <= 1'b0;
		repeat (HALF_MS_CYCLES + 100) @(posedge ref_clk);
		pe <= 1'b1;
		@(posedge ref_clk) pe <= 1'b0;
		repeat (2) @(posedge ref_clk);
		check8(8'(n_first), 8'h02);
		check8(8'(n_qual), 8'h04);
		check8(8'(n_second), 8'h02);
		$display("test pulses done");
		conclude();
	end
endmodule
`default_nettype wire
